// ==== include/rqmh_map.svh ====
// Register offsets, field positions, reset values and CRC constants of the queue threshold and hash block.
`ifndef RQMH_MAP_SVH
`define RQMH_MAP_SVH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets on the parallel host port.
`define RQMH_ADDR_W              12
`define RQMH_OFF_RX_FRAME_THRESH 12'h19c
`define RQMH_OFF_TX_NEXT_SPACE   12'h19e
`define RQMH_OFF_GROUP_HASH0     12'h1a0
`define RQMH_OFF_GROUP_HASH1     12'h1a2
`define RQMH_OFF_GROUP_HASH2     12'h1a4
`define RQMH_OFF_GROUP_HASH3     12'h1a6

////////////////////////////////////////////////////////////////////////////////
// Field positions.
`define RQMH_RX_FRAME_THRESHOLD_VALUE_LSB           0
`define RQMH_RX_FRAME_THRESHOLD_VALUE_MSB           7
`define RQMH_HASH_WORD_SEL_MSB   5
`define RQMH_HASH_WORD_SEL_LSB   4
`define RQMH_HASH_BIT_SEL_MSB    3
`define RQMH_HASH_BIT_SEL_LSB    0
`define RQMH_DA_GROUP_BIT        40

////////////////////////////////////////////////////////////////////////////////
// Reset values.
`define RQMH_RST_RX_FRAME_THRESH 16'h0000
`define RQMH_RST_TX_NEXT_SPACE   16'h0000
`define RQMH_RST_GROUP_HASH      16'h0000

////////////////////////////////////////////////////////////////////////////////
// Hash CRC.
`define RQMH_CRC_POLY            32'h04c11db7
`define RQMH_CRC_INIT            32'hffffffff

`endif

// ==== include/rqmh_pkg.sv ====
// Types shared by the queue threshold and hash filter block.
package rqmh_pkg;

  typedef logic [15:0] rqmh_word_t;
  typedef logic [5:0]  rqmh_hash_idx_t;
  typedef logic [47:0] rqmh_mac_t;

  // Why the filter reached its verdict for one destination address.
  typedef enum logic [1:0] {
    RQMH_WHY_INDIVIDUAL,
    RQMH_WHY_PASS_ALL,
    RQMH_WHY_HASH_HIT,
    RQMH_WHY_HASH_MISS
  } rqmh_why_e;

endpackage

// ==== include/rqmh_crc_if.sv ====
// Carrier between the filter logic and the destination-address hash module.
`timescale 1ns/10ps
interface rqmh_crc_if;
  import rqmh_pkg::*;

  rqmh_mac_t      da;
  rqmh_hash_idx_t index;

  modport filt_end (output da, input index);
  modport crc_end  (input da, output index);
endinterface

// ==== verilog/rqmh_hash_crc.sv ====
// Destination-address hash: six top bits of the frame check CRC over the address.
`timescale 1ns/10ps
`include "rqmh_map.svh"
module rqmh_hash_crc (
  rqmh_crc_if.crc_end bus
);
  import rqmh_pkg::*;

  // Bytes go in wire order (first byte in da[47:40]), each byte least significant bit first.
  always_comb begin
    logic [31:0] crc;
    logic        fb;
    crc = `RQMH_CRC_INIT;
    fb  = 1'b0;
    for (int b = 0; b < 6; b++) begin
      for (int k = 0; k < 8; k++) begin
        fb  = crc[31] ^ bus.da[47 - 8 * b - 7 + k];
        crc = {crc[30:0], 1'b0} ^ (fb ? `RQMH_CRC_POLY : 32'h00000000);
      end
    end
    bus.index = crc[31:26];
  end

endmodule // rqmh_hash_crc

// ==== verilog/rqmh_top.sv ====
// Receive frame threshold, transmit space request and group address hash filter of the queue manager.
`timescale 1ns/10ps
`include "rqmh_map.svh"

module rqmh_top #(
  parameter int TH_W    = 8,
  parameter int SPACE_W = 16
) (
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_rst_n,
  // Parallel host register port.
  input  wire logic [`RQMH_ADDR_W-1:0] i_reg_addr,
  input  wire logic                  i_reg_wr,
  input  wire logic                  i_reg_rd,
  input  wire logic [1:0]            i_reg_be,
  input  wire rqmh_pkg::rqmh_word_t  i_reg_wdata,
  output rqmh_pkg::rqmh_word_t       o_reg_rdata,
  output logic                       o_reg_rvalid,
  // Receive queue threshold.
  input  wire logic                  i_rx_thresh_int_en,
  input  wire logic [TH_W-1:0]       i_rx_frame_count,
  input  wire logic                  i_rx_status_clr,
  output logic                       o_rx_status,
  // Transmit queue space monitor.
  input  wire logic                  i_tx_space_mon_en,
  input  wire logic [SPACE_W-1:0]    i_tx_free_dwords,
  input  wire logic                  i_tx_space_clr,
  output logic                       o_tx_space_status,
  // Group address filter.
  input  wire logic                  i_hash_perfect_mode,
  input  wire logic                  i_rx_all,
  input  wire logic                  i_mcast_mac_filt,
  input  wire logic                  i_da_valid,
  input  wire rqmh_pkg::rqmh_mac_t   i_da,
  output logic                       o_filt_valid,
  output logic                       o_filt_group,
  output logic                       o_filt_accept,
  output rqmh_pkg::rqmh_why_e        o_filt_why,
  output rqmh_pkg::rqmh_hash_idx_t   o_filt_index
);
  import rqmh_pkg::*;

  if (TH_W < 1 || TH_W > 8) begin : g_bad_th
    $error("TH_W must lie between 1 and 8");
  end
  if (SPACE_W < 1 || SPACE_W > 16) begin : g_bad_space
    $error("SPACE_W must lie between 1 and 16");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register file state.
  rqmh_word_t     rx_frame_threshold_ff;
  rqmh_word_t     nxt_rx_frame_threshold_ff;
  rqmh_word_t     tx_next_space_request_ff;
  rqmh_word_t     nxt_tx_next_space_request_ff;
  rqmh_word_t     group_hash_ff     [4];
  rqmh_word_t     nxt_group_hash_ff [4];
  rqmh_word_t     rdata_ff;
  rqmh_word_t     nxt_rdata_ff;
  logic           rvalid_ff;
  logic           nxt_rvalid_ff;
  logic           tx_req_written;

  // Merges a write into a word under the two byte enables.
  function automatic rqmh_word_t merge_bytes(input rqmh_word_t old_v, input rqmh_word_t new_v,
                                             input logic [1:0] be);
    rqmh_word_t r;
    r = old_v;
    if (be[0]) begin
      r[7:0] = new_v[7:0];
    end
    if (be[1]) begin
      r[15:8] = new_v[15:8];
    end
    return r;
  endfunction

  always_comb begin
    nxt_rx_frame_threshold_ff    = rx_frame_threshold_ff;
    nxt_tx_next_space_request_ff = tx_next_space_request_ff;
    for (int i = 0; i < 4; i++) begin
      nxt_group_hash_ff[i] = group_hash_ff[i];
    end
    tx_req_written = 1'b0;
    if (i_reg_wr) begin
      unique case (i_reg_addr)
        `RQMH_OFF_RX_FRAME_THRESH: begin
          // The reserved high byte is stored as written.
          nxt_rx_frame_threshold_ff = merge_bytes(rx_frame_threshold_ff, i_reg_wdata, i_reg_be);
        end
        `RQMH_OFF_TX_NEXT_SPACE: begin
          nxt_tx_next_space_request_ff = merge_bytes(tx_next_space_request_ff, i_reg_wdata, i_reg_be);
          tx_req_written               = |i_reg_be;
        end
        `RQMH_OFF_GROUP_HASH0: begin
          nxt_group_hash_ff[0] = merge_bytes(group_hash_ff[0], i_reg_wdata, i_reg_be);
        end
        `RQMH_OFF_GROUP_HASH1: begin
          nxt_group_hash_ff[1] = merge_bytes(group_hash_ff[1], i_reg_wdata, i_reg_be);
        end
        `RQMH_OFF_GROUP_HASH2: begin
          nxt_group_hash_ff[2] = merge_bytes(group_hash_ff[2], i_reg_wdata, i_reg_be);
        end
        `RQMH_OFF_GROUP_HASH3: begin
          nxt_group_hash_ff[3] = merge_bytes(group_hash_ff[3], i_reg_wdata, i_reg_be);
        end
        default: begin
          // Other offsets belong to neighbouring blocks; the write is ignored here.
        end
      endcase
    end
  end

  // Read data is registered so the host port sees it one cycle after the strobe.
  always_comb begin
    nxt_rvalid_ff = i_reg_rd;
    nxt_rdata_ff  = 16'h0000;
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        `RQMH_OFF_RX_FRAME_THRESH: nxt_rdata_ff = rx_frame_threshold_ff;
        `RQMH_OFF_TX_NEXT_SPACE:   nxt_rdata_ff = tx_next_space_request_ff;
        `RQMH_OFF_GROUP_HASH0:     nxt_rdata_ff = group_hash_ff[0];
        `RQMH_OFF_GROUP_HASH1:     nxt_rdata_ff = group_hash_ff[1];
        `RQMH_OFF_GROUP_HASH2:     nxt_rdata_ff = group_hash_ff[2];
        `RQMH_OFF_GROUP_HASH3:     nxt_rdata_ff = group_hash_ff[3];
        default:                   nxt_rdata_ff = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      rx_frame_threshold_ff    <= `RQMH_RST_RX_FRAME_THRESH;
      tx_next_space_request_ff <= `RQMH_RST_TX_NEXT_SPACE;
      for (int i = 0; i < 4; i++) begin
        group_hash_ff[i] <= `RQMH_RST_GROUP_HASH;
      end
      rdata_ff  <= 16'h0000;
      rvalid_ff <= 1'b0;
    end else begin
      rx_frame_threshold_ff    <= nxt_rx_frame_threshold_ff;
      tx_next_space_request_ff <= nxt_tx_next_space_request_ff;
      for (int i = 0; i < 4; i++) begin
        group_hash_ff[i] <= nxt_group_hash_ff[i];
      end
      rdata_ff  <= nxt_rdata_ff;
      rvalid_ff <= nxt_rvalid_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receive threshold and transmit space status.
  logic [TH_W-1:0]    rx_frame_threshold_value;
  logic [SPACE_W-1:0] tx_space_req_dwords;
  logic               rx_cond;
  logic               tx_cond;
  logic               rx_cond_ff;
  logic               nxt_rx_cond_ff;
  logic               tx_cond_ff;
  logic               nxt_tx_cond_ff;
  logic               rx_status_ff;
  logic               nxt_rx_status_ff;
  logic               tx_status_ff;
  logic               nxt_tx_status_ff;

  assign rx_frame_threshold_value = rx_frame_threshold_ff[TH_W-1:0];
  // The request is a double-word count, the same unit as the free-space input.
  assign tx_space_req_dwords      = tx_next_space_request_ff[SPACE_W-1:0];

  // A threshold of zero still works as a compare here, but software is told to keep it at one or more.
  // Writing one while reception runs is left to software; nothing here guards against it.
  assign rx_cond = i_rx_thresh_int_en && (i_rx_frame_count > rx_frame_threshold_value);
  assign tx_cond = i_tx_space_mon_en && (i_tx_free_dwords >= tx_space_req_dwords);

  // Status is edge-triggered: it sets when the condition appears, so clearing it while the
  // condition persists does not immediately set it again. A new space request re-arms the monitor.
  always_comb begin
    nxt_rx_cond_ff   = rx_cond;
    nxt_tx_cond_ff   = tx_req_written ? 1'b0 : tx_cond;
    nxt_rx_status_ff = rx_status_ff;
    nxt_tx_status_ff = tx_status_ff;
    if (i_rx_status_clr) begin
      nxt_rx_status_ff = 1'b0;
    end
    if (rx_cond && !rx_cond_ff) begin
      nxt_rx_status_ff = 1'b1;
    end
    if (i_tx_space_clr) begin
      nxt_tx_status_ff = 1'b0;
    end
    if (tx_cond && !tx_cond_ff) begin
      nxt_tx_status_ff = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      rx_cond_ff   <= 1'b0;
      tx_cond_ff   <= 1'b0;
      rx_status_ff <= 1'b0;
      tx_status_ff <= 1'b0;
    end else begin
      rx_cond_ff   <= nxt_rx_cond_ff;
      tx_cond_ff   <= nxt_tx_cond_ff;
      rx_status_ff <= nxt_rx_status_ff;
      tx_status_ff <= nxt_tx_status_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Group address hash filter.
  rqmh_crc_if crc_bus ();

  rqmh_hash_crc u_hash_crc (
    .bus (crc_bus.crc_end)
  );

  assign crc_bus.da = i_da;

  logic           da_group;
  logic           hash_bit;
  logic           filt_valid_ff;
  logic           nxt_filt_valid_ff;
  logic           filt_group_ff;
  logic           nxt_filt_group_ff;
  logic           filt_accept_ff;
  logic           nxt_filt_accept_ff;
  rqmh_why_e      filt_why_ff;
  rqmh_why_e      nxt_filt_why_ff;
  rqmh_hash_idx_t filt_index_ff;
  rqmh_hash_idx_t nxt_filt_index_ff;

  // The group bit is the least significant bit of the first address byte on the wire.
  assign da_group = i_da[`RQMH_DA_GROUP_BIT];
  assign hash_bit = group_hash_ff[crc_bus.index[`RQMH_HASH_WORD_SEL_MSB:`RQMH_HASH_WORD_SEL_LSB]]
                                 [crc_bus.index[`RQMH_HASH_BIT_SEL_MSB:`RQMH_HASH_BIT_SEL_LSB]];

  // Outside hash-perfect mode this block does not judge group frames; other filters do.
  always_comb begin
    nxt_filt_valid_ff  = i_da_valid;
    nxt_filt_group_ff  = filt_group_ff;
    nxt_filt_accept_ff = filt_accept_ff;
    nxt_filt_why_ff    = filt_why_ff;
    nxt_filt_index_ff  = filt_index_ff;
    if (i_da_valid) begin
      nxt_filt_group_ff = da_group;
      nxt_filt_index_ff = crc_bus.index;
      if (!da_group) begin
        nxt_filt_accept_ff = 1'b1;
        nxt_filt_why_ff    = RQMH_WHY_INDIVIDUAL;
      end else if ((i_rx_all && i_mcast_mac_filt) || !i_hash_perfect_mode) begin
        nxt_filt_accept_ff = 1'b1;
        nxt_filt_why_ff    = RQMH_WHY_PASS_ALL;
      end else if (hash_bit) begin
        nxt_filt_accept_ff = 1'b1;
        nxt_filt_why_ff    = RQMH_WHY_HASH_HIT;
      end else begin
        nxt_filt_accept_ff = 1'b0;
        nxt_filt_why_ff    = RQMH_WHY_HASH_MISS;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      filt_valid_ff  <= 1'b0;
      filt_group_ff  <= 1'b0;
      filt_accept_ff <= 1'b0;
      filt_why_ff    <= RQMH_WHY_INDIVIDUAL;
      filt_index_ff  <= 6'h00;
    end else begin
      filt_valid_ff  <= nxt_filt_valid_ff;
      filt_group_ff  <= nxt_filt_group_ff;
      filt_accept_ff <= nxt_filt_accept_ff;
      filt_why_ff    <= nxt_filt_why_ff;
      filt_index_ff  <= nxt_filt_index_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from a flip-flop.
  assign o_reg_rdata       = rdata_ff;
  assign o_reg_rvalid      = rvalid_ff;
  assign o_rx_status       = rx_status_ff;
  assign o_tx_space_status = tx_status_ff;
  assign o_filt_valid      = filt_valid_ff;
  assign o_filt_group      = filt_group_ff;
  assign o_filt_accept     = filt_accept_ff;
  assign o_filt_why        = filt_why_ff;
  assign o_filt_index      = filt_index_ff;

endmodule // rqmh_top

// ==== tb/rqmh_top_monitor.sv ====
// Port checker of the queue threshold and hash filter block.
`timescale 1ns/10ps
`include "rqmh_map.svh"
module rqmh_top_monitor #(
  parameter int TH_W    = 8,
  parameter int SPACE_W = 16
) (
  input wire logic                   i_sys_clk,
  input wire logic                   i_rst_n,
  input wire logic [`RQMH_ADDR_W-1:0] i_reg_addr,
  input wire logic                   i_reg_wr,
  input wire logic                   i_reg_rd,
  input wire logic [1:0]             i_reg_be,
  input wire rqmh_pkg::rqmh_word_t   i_reg_wdata,
  input wire rqmh_pkg::rqmh_word_t   o_reg_rdata,
  input wire logic                   o_reg_rvalid,
  input wire logic                   i_rx_thresh_int_en,
  input wire logic [TH_W-1:0]        i_rx_frame_count,
  input wire logic                   i_rx_status_clr,
  input wire logic                   o_rx_status,
  input wire logic                   i_tx_space_mon_en,
  input wire logic [SPACE_W-1:0]     i_tx_free_dwords,
  input wire logic                   i_tx_space_clr,
  input wire logic                   o_tx_space_status,
  input wire logic                   i_hash_perfect_mode,
  input wire logic                   i_rx_all,
  input wire logic                   i_mcast_mac_filt,
  input wire logic                   i_da_valid,
  input wire rqmh_pkg::rqmh_mac_t    i_da,
  input wire logic                   o_filt_valid,
  input wire logic                   o_filt_group,
  input wire logic                   o_filt_accept,
  input wire rqmh_pkg::rqmh_why_e    o_filt_why,
  input wire rqmh_pkg::rqmh_hash_idx_t o_filt_index
);
  import rqmh_pkg::*;
  ////////////////////////////////////////////////////////
  // The six words sit in one vector so a read can be predicted by slot.
  logic [95:0] regs_ff, nxt_regs;
  logic [3:0]  slot;
  logic        mapped, cond_rx, cond_tx;
  rqmh_word_t  exp_rd, lane;
  assign slot = 4'((i_reg_addr - `RQMH_OFF_RX_FRAME_THRESH) >> 1);
  assign mapped = i_reg_addr >= `RQMH_OFF_RX_FRAME_THRESH && i_reg_addr <= `RQMH_OFF_GROUP_HASH3 && !i_reg_addr[0];
  assign exp_rd = mapped ? regs_ff[slot*16 +: 16] : 16'h0000;
  assign lane = {i_reg_be[1] ? i_reg_wdata[15:8] : exp_rd[15:8], i_reg_be[0] ? i_reg_wdata[7:0] : exp_rd[7:0]};
  assign cond_rx = i_rx_thresh_int_en && i_rx_frame_count > regs_ff[7:0];
  assign cond_tx = i_tx_space_mon_en && i_tx_free_dwords >= regs_ff[31:16];
  always_comb begin
    nxt_regs = regs_ff;
    if (i_reg_wr && mapped) begin
      nxt_regs[slot*16 +: 16] = lane;
    end
  end
  always_ff @(posedge i_sys_clk) begin
    regs_ff <= i_rst_n ? nxt_regs : '0;
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_group;
    i_da_valid && i_da[`RQMH_DA_GROUP_BIT];
  endsequence
  property p_read;
    i_reg_rd |=> o_reg_rvalid && o_reg_rdata == $past(exp_rd);
  endproperty
  a_read: assert property (p_read) else $error("read answer wrong");
  property p_rx_set;
    $rose(cond_rx) |=> o_rx_status;
  endproperty
  a_rx_set: assert property (p_rx_set) else $error("rx status not set");
  property p_rx_clr;
    i_rx_status_clr && !$rose(cond_rx) |=> !o_rx_status;
  endproperty
  a_rx_clr: assert property (p_rx_clr) else $error("rx status not cleared");
  property p_sticky;
    (o_rx_status && !i_rx_status_clr |=> o_rx_status)
      and (o_tx_space_status && !i_tx_space_clr |=> o_tx_space_status);
  endproperty
  a_sticky: assert property (p_sticky) else $error("status lost");
  property p_tx_set;
    $rose(cond_tx) |=> o_tx_space_status;
  endproperty
  a_tx_set: assert property (p_tx_set) else $error("tx status not set");
  property p_indiv;
    i_da_valid && !i_da[`RQMH_DA_GROUP_BIT] |=> o_filt_valid && !o_filt_group && o_filt_accept;
  endproperty
  a_indiv: assert property (p_indiv) else $error("individual verdict wrong");
  property p_pass;
    s_group ##0 (!i_hash_perfect_mode || i_rx_all && i_mcast_mac_filt)
      |=> o_filt_accept && o_filt_why == RQMH_WHY_PASS_ALL;
  endproperty
  a_pass: assert property (p_pass) else $error("pass all verdict wrong");
  property p_hash;
    s_group ##0 (i_hash_perfect_mode && !(i_rx_all && i_mcast_mac_filt)) |=> o_filt_valid && o_filt_group
      && o_filt_accept == regs_ff[32 + o_filt_index]
      && o_filt_why == (o_filt_accept ? RQMH_WHY_HASH_HIT : RQMH_WHY_HASH_MISS);
  endproperty
  a_hash: assert property (p_hash) else $error("hash verdict wrong");
endmodule // rqmh_top_monitor

bind rqmh_top rqmh_top_monitor #(.TH_W(TH_W), .SPACE_W(SPACE_W)) u_mon (.*);

// ==== tb/rqmh_host_model.sv ====
// Host processor model that drives the parallel register port.
`timescale 1ns/10ps
`include "rqmh_map.svh"
module rqmh_host_model (
  input  wire logic                  i_sys_clk,
  input  wire rqmh_pkg::rqmh_word_t  i_reg_rdata,
  input  wire logic                  i_reg_rvalid,
  output logic [`RQMH_ADDR_W-1:0]    o_reg_addr = 12'h000,
  output logic                       o_reg_wr = 1'b0,
  output logic                       o_reg_rd = 1'b0,
  output logic [1:0]                 o_reg_be = 2'b00,
  output rqmh_pkg::rqmh_word_t       o_reg_wdata = 16'h0000
);
  import rqmh_pkg::*;
  ////////////////////////////////////////////////////////
  // Each access is followed by an idle cycle with the address inverted, and a write's data too, so nothing stale looks valid.
  task automatic wr(input logic [11:0] a, input logic [1:0] b, input rqmh_word_t d);
    o_reg_addr <= a;
    o_reg_be <= b;
    o_reg_wdata <= d;
    o_reg_wr <= 1'b1;
    @(posedge i_sys_clk);
    o_reg_wr <= 1'b0;
    o_reg_addr <= ~a;
    o_reg_wdata <= ~d;
    @(posedge i_sys_clk);
  endtask
  task automatic rd(input logic [11:0] a, output rqmh_word_t d);
    o_reg_addr <= a;
    o_reg_rd <= 1'b1;
    @(posedge i_sys_clk);
    o_reg_rd <= 1'b0;
    o_reg_addr <= ~a;
    @(posedge i_sys_clk);
    d = (i_reg_rvalid === 1'b1) ? i_reg_rdata : 16'hxxxx;
  endtask
endmodule // rqmh_host_model

// ==== tb/rqmh_top_tb.sv ====
// Self-checking bench of the queue threshold and hash filter block.
`timescale 1ns/10ps
`include "rqmh_map.svh"
module rqmh_top_tb;
  import rqmh_pkg::*;
  typedef struct packed {rqmh_mac_t da; logic hp; logic ra; logic mf; logic prog;} rqmh_row_s;
  logic i_sys_clk = 1'b0, i_rst_n = 1'b0, i_rx_thresh_int_en = 1'b0, i_rx_status_clr = 1'b0;
  logic i_tx_space_mon_en = 1'b0, i_tx_space_clr = 1'b0, i_hash_perfect_mode = 1'b0;
  logic i_rx_all = 1'b0, i_mcast_mac_filt = 1'b0, i_da_valid = 1'b0;
  logic [7:0] i_rx_frame_count = 8'h00;
  logic [15:0] i_tx_free_dwords = 16'h0000;
  rqmh_mac_t i_da = 48'h000000000000;
  wire logic [11:0] i_reg_addr;
  wire logic i_reg_wr, i_reg_rd;
  wire logic [1:0] i_reg_be;
  wire rqmh_word_t i_reg_wdata;
  rqmh_word_t o_reg_rdata, rd_word;
  logic o_reg_rvalid, o_rx_status, o_tx_space_status, o_filt_valid, o_filt_group, o_filt_accept;
  rqmh_why_e o_filt_why;
  rqmh_hash_idx_t o_filt_index;
  logic [63:0] tbl = 64'h0;
  int failures = 0, tests_run = 0, cycles = 0;
  rqmh_row_s rows [8] = '{'{48'h001122334455, 1, 0, 0, 0}, '{48'h01005e000001, 1, 0, 0, 1},
    '{48'h01005e0000fb, 1, 0, 0, 0}, '{48'h333300000001, 1, 0, 0, 1}, '{48'hffffffffffff, 1, 1, 0, 0},
    '{48'h01005e7fffff, 0, 0, 0, 0}, '{48'h01005e0000fb, 1, 1, 1, 0}, '{48'h0180c2000000, 1, 0, 1, 0}};
  rqmh_top dut (.*);
  rqmh_host_model host (.i_sys_clk(i_sys_clk), .i_reg_rdata(o_reg_rdata), .i_reg_rvalid(o_reg_rvalid),
    .o_reg_addr(i_reg_addr), .o_reg_wr(i_reg_wr), .o_reg_rd(i_reg_rd), .o_reg_be(i_reg_be), .o_reg_wdata(i_reg_wdata));
  ////////////////////////////////////////////////////////
  always #10 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 4000) begin
      failures++;
      close_out();
    end
  end
  task automatic close_out();
    if (failures == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask
  task automatic chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Frame check CRC, address bytes in wire order and each byte low bit first.
  function automatic rqmh_hash_idx_t hidx(input rqmh_mac_t a);
    logic [31:0] c;
    c = `RQMH_CRC_INIT;
    for (int i = 0; i < 48; i++) begin
      c = {c[30:0], 1'b0} ^ ((c[31] ^ a[40 - 8 * (i / 8) + i % 8]) ? `RQMH_CRC_POLY : 32'h0);
    end
    return c[31:26];
  endfunction
  task automatic filt(input rqmh_row_s r);
    rqmh_why_e why;
    i_hash_perfect_mode <= r.hp;
    i_rx_all <= r.ra;
    i_mcast_mac_filt <= r.mf;
    i_da <= r.da;
    i_da_valid <= 1'b1;
    tick(1);
    i_da_valid <= 1'b0;
    i_da <= ~r.da;
    tick(1);
    if (!r.da[40]) why = RQMH_WHY_INDIVIDUAL;
    else if (!r.hp || r.ra && r.mf) why = RQMH_WHY_PASS_ALL;
    else why = tbl[hidx(r.da)] ? RQMH_WHY_HASH_HIT : RQMH_WHY_HASH_MISS;
    chk("filt_valid", 1, o_filt_valid);
    chk("filt_group", r.da[40], o_filt_group);
    chk("filt_why", why, o_filt_why);
    chk("filt_accept", why != RQMH_WHY_HASH_MISS, o_filt_accept);
    if (r.da[40]) chk("filt_index", hidx(r.da), o_filt_index);
  endtask
  initial begin
    tick(16);
    i_rst_n <= 1'b1;
    chk("reset_outs", 0, {o_reg_rvalid, o_reg_rdata, o_rx_status, o_tx_space_status, o_filt_valid,
                          o_filt_group, o_filt_accept, o_filt_why, o_filt_index});
    for (int a = 'h19c; a <= 'h1a8; a += 2) begin
      host.rd(12'(a), rd_word);
      chk("reg_reset", 0, rd_word);
    end
    filt(rows[1]);
    for (int a = 'h19c; a <= 'h1a8; a += 2) host.wr(12'(a), 2'b11, 16'ha5c3 ^ 16'(a));
    for (int a = 'h19c; a <= 'h1a8; a += 2) begin
      host.rd(12'(a), rd_word);
      chk("reg_rw", (a == 'h1a8) ? 16'h0 : 16'ha5c3 ^ 16'(a), rd_word);
    end
    // Threshold of two: at least one, and never zero, as software must ensure.
    host.wr(12'h19c, 2'b01, 16'h7e02);
    host.wr(12'h19c, 2'b00, 16'hffff);
    host.rd(12'h19c, rd_word);
    chk("thr_lanes", (16'ha5c3 ^ 16'h019c) & 16'hff00 | 16'h0002, rd_word);
    i_rx_thresh_int_en <= 1'b1;
    i_rx_frame_count <= 8'd2;
    tick(3);
    chk("rx_at_thr", 0, o_rx_status);
    i_rx_frame_count <= 8'd3;
    tick(2);
    chk("rx_over_thr", 1, o_rx_status);
    host.rd(12'h19c, rd_word);
    chk("rx_after_read", 1, o_rx_status);
    i_rx_status_clr <= 1'b1;
    tick(1);
    i_rx_status_clr <= 1'b0;
    i_rx_thresh_int_en <= 1'b0;
    tick(1);
    i_rx_frame_count <= 8'd9;
    tick(3);
    chk("rx_cleared_off", 0, o_rx_status);
    i_rx_thresh_int_en <= 1'b1;
    tick(2);
    chk("rx_enabled", 1, o_rx_status);
    // A clear that lands on the same edge as a new rise must lose to the set.
    i_rx_thresh_int_en <= 1'b0;
    tick(1);
    i_rx_status_clr <= 1'b1;
    i_rx_thresh_int_en <= 1'b1;
    tick(1);
    i_rx_status_clr <= 1'b0;
    tick(1);
    chk("rx_set_wins", 1, o_rx_status);
    // Space request of sixteen double words, written before the frame.
    host.wr(12'h19e, 2'b11, 16'h0010);
    i_tx_free_dwords <= 16'h000f;
    i_tx_space_mon_en <= 1'b1;
    tick(3);
    chk("tx_short", 0, o_tx_space_status);
    i_tx_free_dwords <= 16'h0010;
    tick(2);
    chk("tx_equal", 1, o_tx_space_status);
    i_tx_space_clr <= 1'b1;
    tick(1);
    i_tx_space_clr <= 1'b0;
    host.wr(12'h19e, 2'b11, 16'h0020);
    tick(2);
    chk("tx_rearm_short", 0, o_tx_space_status);
    i_tx_free_dwords <= 16'h0020;
    tick(2);
    chk("tx_rearm", 1, o_tx_space_status);
    foreach (rows[i]) if (rows[i].prog) tbl[hidx(rows[i].da)] = 1'b1;
    for (int w = 0; w < 4; w++) host.wr(12'h1a0 + 12'(2 * w), 2'b11, tbl[w * 16 +: 16]);
    foreach (rows[i]) filt(rows[i]);
    close_out();
  end
endmodule // rqmh_top_tb
